//--- hdl/nexus_pkg.sv
// Constants and types shared by the port event logic.
package nexus_pkg;
    // Port state machine encoding.
    typedef enum logic [1:0] {
        port_initial_state = 2'h0,
        port_login_state = 2'h1,
        port_logged_in_state = 2'h2,
        port_logout_state = 2'h3
    } port_state_type;

    localparam int unsigned clk_hz = 10000000;
    localparam int unsigned ethernet_baud = 9600;
    localparam int unsigned bits_per_byte = 10;
    // Cycles per byte time at the fixed Ethernet-equivalent rate.
    localparam int unsigned eth_byte_cycles = clk_hz / (ethernet_baud / bits_per_byte);
    localparam logic [23:0] eth_byte_cycles_w = eth_byte_cycles[23:0];
    localparam logic [23:0] byte_time_reset = 24'h000000;
    localparam logic [23:0] timeout_reset = 24'h000000;
    localparam logic [3:0] timeout_bytes = 4'h4;
    localparam logic [1:0] port_state_reset = 2'h0;
endpackage

//--- hdl/nexus_if.sv
// Interface carrying the event strobes between top and the event combiner.
`timescale 1ns/1ps
`default_nettype none
interface nexus_if;
    logic [5:0] cause;
    logic loss;
    modport src (output cause, input loss);
    modport comb (input cause, output loss);
endinterface
`default_nettype wire

//--- hdl/nexus_combine.sv
// Merges simultaneous nexus-loss causes into one registered pulse.
`timescale 1ns/1ps
`default_nettype none
module nexus_combine (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Cause strobes and merged pulse.
    nexus_if.comb ev
);
    import nexus_pkg::*;
    logic loss_q;
    wire any_cause = |ev.cause;

    // One pulse per cycle however many causes fire.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            loss_q <= 1'b0;
        end else begin
            loss_q <= any_cause;
        end
    end
    assign ev.loss = loss_q;
endmodule
`default_nettype wire

//--- hdl/port_nexus_loss_and_ack_timeout.sv
// Per-port nexus-loss detection and acknowledgement time-out selection.
`timescale 1ns/1ps
`default_nettype none
module port_nexus_loss_and_ack_timeout (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Interconnect selection and port role.
    input wire logic use_ethernet,
    input wire logic is_drive,
    // Link layer events, same clock domain.
    input wire logic login_tx,
    input wire logic login_rx,
    input wire logic exchange_abort_flag,
    input wire logic dev_reset_tx,
    input wire logic ack_rx,
    input wire logic reset_indication,
    input wire logic closed_indication,
    input wire logic close_event,
    // Port state machine requests.
    input wire logic login_start,
    input wire logic login_done,
    input wire logic logout,
    // Pins from the bus.
    input wire logic sense_automation,
    input wire logic sense_drive,
    input wire logic reset_request,
    // Operating parameters.
    input wire logic params_change,
    input wire logic [23:0] serial_byte_cycles,
    // Outputs.
    output logic nexus_loss,
    output nexus_pkg::port_state_type port_state,
    output logic [23:0] ack_byte_cycles,
    output logic [27:0] ack_timeout_cycles
);
    import nexus_pkg::*;

    port_state_type state_q, state_d;
    logic reset_pend_q;
    logic [23:0] byte_q;
    logic [27:0] tmo_q;
    logic nexus_q;
    // This port owns exactly one interconnect binding, carried by this one bundle.
    // Every cause strobe below belongs to the single remote port that it pairs with.
    // A shared TCP link hands each port its own strobes, so pairings never mix.
    nexus_if ev ();

    // How the block is put together.
    // Same-domain strobes from the link layer go straight into the cause decode.
    // The three bus pins are asynchronous and each passes a two-stage synchroniser.
    // A third stage per pin holds the previous settled level for edge detection.
    // All causes of one cycle are merged by the combiner into a single pulse.
    // The merged pulse is registered once more so the output comes from a flop.
    // The loss output therefore follows a same-domain cause by two clock edges.
    // A pin change shows up about four to five edges after it reaches the pin.
    // The port state machine is kept here only as far as the loss rules need it.
    // A close event beats any state machine request in the same cycle; a device reset sent in that cycle is still held pending.
    // The time-out period is latched on a parameter change and held after that.
    // Holding it means frames already in flight keep the period they began with.
    // Users must pulse the parameter change strobe after setting the byte time.
    // Reset clears the synchronisers to zero, so a pin held low through reset
    // produces no falling edge when reset is released.
    // A pin already high at release gives a rising edge only on the reset request
    // pin, which is treated as a real request; hold that pin low during reset.

    // Bus pins in one vector: bit 0 automation sense, bit 1 drive sense, bit 2 reset.
    wire [2:0] pin_raw = {reset_request, sense_drive, sense_automation};
    wire [2:0] pin_s1;
    wire [2:0] pin_s2;
    genvar g;

    // Pin synchronisers, one per pin: stage 0 feeds only stage 1.
    // Stages 1 and 2 are both settled, so edges are taken between them.
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            logic [2:0] sh_q;
            wire [2:0] sh_d = {sh_q[1:0], pin_raw[g]};
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    sh_q <= 3'h0;
                end else begin
                    sh_q <= sh_d;
                end
            end
            assign pin_s1[g] = sh_q[1];
            assign pin_s2[g] = sh_q[2];
        end
    endgenerate

    // Drive watches automation sense, automation watches drive sense.
    // A fall is old level high and new level low on the watched pin.
    wire fall_automation = pin_s2[0] & ~pin_s1[0];
    wire fall_drive = pin_s2[1] & ~pin_s1[1];
    wire sense_lost = is_drive ? fall_automation : fall_drive;
    // The reset request acts once, on its rising edge, however long it is held.
    wire reset_pulse = pin_s1[2] & ~pin_s2[2];
    wire reset_any = reset_indication | reset_pulse;

    // Remember an outstanding device reset until its acknowledgement.
    // A new device reset in the same cycle as an acknowledgement wins, so the
    // later acknowledgement still pairs with it; a close event drops the pairing.
    wire reset_clear = ack_rx | close_event;
    wire reset_pend_d = dev_reset_tx | (reset_pend_q & ~reset_clear);

    // Pending flag register.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            reset_pend_q <= 1'b0;
        end else begin
            reset_pend_q <= reset_pend_d;
        end
    end

    // Cause decode; this port owns one interconnect binding so all events are its own.
    wire in_session = (state_q == port_login_state) || (state_q == port_logged_in_state);
    assign ev.cause[0] = login_tx & exchange_abort_flag;
    assign ev.cause[1] = login_rx & exchange_abort_flag;
    assign ev.cause[2] = ack_rx & reset_pend_q;
    assign ev.cause[3] = sense_lost;
    assign ev.cause[4] = reset_any;
    assign ev.cause[5] = closed_indication & in_session;

    nexus_combine u_combine (
        .clk(clk),
        .nrst(nrst),
        .ev(ev)
    );

    // Port state machine next state; close event overrides everything.
    always_comb begin
        state_d = state_q;
        case (state_q)
            port_initial_state: begin
                if (login_start) state_d = port_login_state;
            end
            port_login_state: begin
                if (login_done) state_d = port_logged_in_state;
            end
            port_logged_in_state: begin
                if (logout) state_d = port_logout_state;
            end
            port_logout_state: begin
                if (login_start) state_d = port_login_state;
            end
            default: begin
                state_d = port_initial_state;
            end
        endcase
        if (close_event) state_d = port_initial_state;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= port_initial_state;
        end else begin
            state_q <= state_d;
        end
    end

    // Byte time selection: Ethernet ignores negotiated rate.
    wire [23:0] byte_sel = use_ethernet ? eth_byte_cycles_w : serial_byte_cycles;
    // The period is a fixed number of byte times; 24 bits times four fit in 28.
    wire [27:0] tmo_sel = 28'(byte_sel) * 28'(timeout_bytes);
    // Take a fresh period on each parameter change, otherwise keep the old one.
    wire [23:0] byte_d = params_change ? byte_sel : byte_q;
    wire [27:0] tmo_d = params_change ? tmo_sel : tmo_q;

    // Period registers; they hold for every frame sent after the change.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            byte_q <= byte_time_reset;
            tmo_q <= {4'h0, timeout_reset};
        end else begin
            byte_q <= byte_d;
            tmo_q <= tmo_d;
        end
    end

    // Output stage of the merged loss pulse, so the pin comes from a flop.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            nexus_q <= 1'b0;
        end else begin
            nexus_q <= ev.loss;
        end
    end

    // Outputs straight from their registers.
    assign nexus_loss = nexus_q;
    assign port_state = state_q;
    assign ack_byte_cycles = byte_q;
    assign ack_timeout_cycles = tmo_q;
endmodule
`default_nettype wire

//--- tb/nexus_props.sv
// Assertions on the port event logic.
`timescale 1ns/1ps
`default_nettype none
module nexus_props (
    // Watched ports.
    input wire logic clk, nrst, use_ethernet, is_drive, login_tx, login_rx,
    input wire logic exchange_abort_flag, reset_indication, closed_indication,
    input wire logic close_event, sense_automation, params_change, nexus_loss,
    input wire logic [23:0] serial_byte_cycles, ack_byte_cycles,
    input wire logic [27:0] ack_timeout_cycles,
    input wire nexus_pkg::port_state_type port_state
);
    import nexus_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Aborts, reset indication, closed indication and automation sense fall at a drive show as a loss pulse after the documented delay.
    chk_tx_abort:
        assert property (login_tx && exchange_abort_flag |-> ##2 nexus_loss) else $error("tx");
    chk_rx_abort:
        assert property (login_rx && exchange_abort_flag |-> ##2 nexus_loss) else $error("rx");
    chk_reset_ind:
        assert property (reset_indication |-> ##2 nexus_loss) else $error("ind");
    chk_closed_loss:
        assert property (closed_indication && port_state inside {port_login_state,
            port_logged_in_state} |-> ##2 nexus_loss) else $error("closed");
    chk_sense_fall:
        assert property (is_drive && $fell(sense_automation) |-> ##[3:7] nexus_loss)
            else $error("sense");
    chk_close_init:
        assert property (close_event |=> port_state == port_initial_state) else $error("state");
    // Time-out selection follows a parameter change by one cycle.
    chk_eth_byte:
        assert property (params_change && use_ethernet |=> ack_byte_cycles == eth_byte_cycles_w)
            else $error("eth");
    chk_serial_byte:
        assert property (params_change && !use_ethernet |=>
            ack_byte_cycles == $past(serial_byte_cycles)) else $error("serial");
    chk_timeout_four:
        assert property (params_change |=> ack_timeout_cycles == {2'h0, ack_byte_cycles, 2'h0})
            else $error("timeout");
    // Main scenarios reached.
    cover property (closed_indication && port_state == port_logged_in_state);
    cover property (params_change && use_ethernet);
    cover property (is_drive && $fell(sense_automation));
endmodule
bind port_nexus_loss_and_ack_timeout nexus_props i_nexus_props (.*);
`default_nettype wire

//--- tb/remote_port.sv
// Remote port model that acknowledges device resets.
`timescale 1ns/1ps
`default_nettype none
module remote_port (
    // Clock, request and pacing.
    input wire logic clk,
    input wire logic dev_reset_tx,
    input wire logic slow,
    // Answer.
    output logic ack_rx
);
    logic [2:0] cnt_q = 3'h0;
    // One acknowledgement per device reset, prompt or four cycles late.
    always_ff @(posedge clk) begin
        ack_rx <= cnt_q == 3'h1;
        if (dev_reset_tx) cnt_q <= slow ? 3'h4 : 3'h1;
        else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
    end
endmodule
`default_nettype wire

//--- tb/test_port_nexus_loss_and_ack_timeout.sv
// Self-checking bench for the port event logic.
`timescale 1ns/1ps
`default_nettype none
module test_port_nexus_loss_and_ack_timeout;
    import nexus_pkg::*;
    logic clk = 0, nrst = 0, use_ethernet = 0, is_drive = 1, exchange_abort_flag = 0;
    logic slow = 0, sense_automation = 1, sense_drive = 1, reset_request = 0, ack_rx, nexus_loss;
    logic [9:0] pv = 10'h000;
    logic [23:0] serial_byte_cycles = 24'h000010, ack_byte_cycles;
    logic [27:0] ack_timeout_cycles, n, r;
    logic [31:0] s = 32'h0000002d;
    nexus_pkg::port_state_type port_state;
    int failures = 0, compares = 0;
    // Design and remote partner.
    port_nexus_loss_and_ack_timeout i_port_nexus_loss_and_ack_timeout (.*, .login_tx(pv[9]),
        .login_rx(pv[8]), .dev_reset_tx(pv[7]), .reset_indication(pv[6]),
        .closed_indication(pv[5]), .close_event(pv[4]), .login_start(pv[3]),
        .login_done(pv[2]), .logout(pv[1]), .params_change(pv[0]));
    remote_port i_remote_port (.clk, .dev_reset_tx(pv[7]), .slow, .ack_rx);
    initial forever #50 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    // Loss pulses expected: login aborts and reset indication share one pulse,
    // the acknowledgement of a device reset arrives later and gives its own.
    function automatic logic [27:0] want(input logic [3:0] v, input logic f);
        return 28'((v[3] | v[2]) & f | v[0]) + 28'(v[1]);
    endfunction
    task automatic cmp(input logic [27:0] got, input logic [27:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // Pulses strobes for one cycle and counts loss pulses afterwards.
    task automatic go(input logic [9:0] v, input logic [27:0] exp);
        @(posedge clk) pv <= v;
        @(posedge clk) pv <= 10'h000;
        n = 28'h0;
        repeat (9) @(posedge clk) n = n + nexus_loss;
        cmp(n, exp);
    endtask
    task automatic wrap_up;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1;
        for (int i = 0; i < 24; i++) begin
            s = xs(s);
            exchange_abort_flag <= s[9];
            slow <= s[12];
            go({s[3:0], 6'h00}, want(s[3:0], s[9]));
        end
        $display("%0t random done", $time);
        go(10'h020, 0);
        go(10'h008, 0);
        go(10'h020, 1);
        go(10'h014, 0);
        cmp(28'(port_state), 28'(port_initial_state));
        go(10'h008, 0);
        go(10'h004, 0);
        go(10'h020, 1);
        go(10'h010, 0);
        cmp(28'(port_state), 28'(port_initial_state));
        $display("%0t state done", $time);
        for (int i = 0; i < 6; i++) begin
            s = xs(s);
            use_ethernet <= s[0];
            serial_byte_cycles <= s[31:8];
            go(10'h001, 0);
            r = s[0] ? 28'(eth_byte_cycles) : {4'h0, s[31:8]};
            cmp(28'(ack_byte_cycles), r);
            cmp(ack_timeout_cycles, r << 2);
        end
        $display("%0t timeout done", $time);
        sense_automation <= 0;
        go(10'h000, 1);
        is_drive <= 0;
        sense_automation <= 1;
        go(10'h000, 0);
        sense_drive <= 0;
        go(10'h000, 1);
        sense_automation <= 0;
        go(10'h000, 0);
        reset_request <= 1;
        go(10'h000, 1);
        $display("%0t pins done", $time);
        wrap_up();
    end
endmodule
`default_nettype wire
